/* design/prom_loader.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module prom_loader #(
	parameter int N_EXP = 14
) (
	input  wire logic                core_clk_in,   // core clock
	input  wire logic                rst_n_in,      // async reset
	input  wire logic                load_en_in,    // load strap pin
	input  wire logic [3:0]          prom_sel_in,   // prom address pins
	input  loader_pkg::reg_req_t     reg_in,        // register request
	output logic [31:0]              reg_rdata_out, // register read data
	output loader_pkg::bus_req_t     bus_req_out,   // bus transfer fields
	output logic                     bus_start_out, // bus start pulse
	input  loader_pkg::bus_ans_t     bus_ans_in,    // bus answer
	input  wire logic [15:0][7:0]    hp_out_in,     // per-port hot-plug
	input  wire logic [15:0]         ilock_in,      // interlock per port
	input  wire logic [15:0]         link_up_in,    // link up per port
	input  wire logic [15:0]         link_act_in,   // activity per port
	output logic [15:0]              retention_latch_input_out, // latches
	output logic [15:0]              prst_out,      // partition resets
	output logic                     halt_out,      // hold after reset
	output logic                     load_done_out  // loading finished
);
	if (N_EXP != loader_pkg::EXP_N) begin : g_chk
		$error("prom_loader: N_EXP must be 14");
	end

	loader_pkg::state_t s;
	loader_pkg::state_t next_s;
	logic [loader_pkg::EXP_N-1:0][15:0] exp_wd;

	// ==========================================================
	// expander output images
	for (genvar e = 0; e < 8; e++) begin : g_hp
		localparam int LO = (e / 2) * 4 + (e % 2);
		assign exp_wd[e] = {hp_out_in[LO+2], hp_out_in[LO]};
	end
	assign exp_wd[8]  = 16'h0000;
	assign exp_wd[9]  = {8'h00, ilock_in[7:0]};
	assign exp_wd[10] = {8'h00, ilock_in[15:8]};
	assign exp_wd[11] = 16'h0000;
	assign exp_wd[12] = ~link_up_in;
	assign exp_wd[13] = ~link_act_in;

	// ==========================================================
	// next state
	always_comb begin
		loader_pkg::pend_t fin;
		logic [7:0]        b;
		logic              exp_rd;
		logic [3:0]        exi_nx;
		fin = loader_pkg::PD_NONE;
		b = bus_ans_in.rdata[7:0];
		exp_rd = (s.exi == loader_pkg::EXP_MRL) ||
			(s.exi == loader_pkg::EXP_PRST);
		exi_nx = (s.exi == loader_pkg::EXP_LAST) ? 4'h0 : s.exi + 4'h1;
		next_s = s;
		next_s.start = 1'b0;
		next_s.rdata = 32'h0000_0000;
		next_s.en_s1 = load_en_in;
		next_s.en_s2 = s.en_s1;
		next_s.sel_s1 = prom_sel_in;
		next_s.sel_s2 = s.sel_s1;

		// register reads
		if (reg_in.rd) begin
			case (reg_in.addr)
				loader_pkg::OFS_CTL: begin
					next_s.rdata[loader_pkg::CTL_IGN] = s.ign;
				end
				loader_pkg::OFS_SWC: begin
					next_s.rdata[loader_pkg::SWC_HALT] = s.halt;
				end
				loader_pkg::OFS_STS: begin
					next_s.rdata[loader_pkg::ST_W-1:0] = s.sts;
				end
				loader_pkg::OFS_ACC: begin
					next_s.rdata = {s.acc_busy, s.acc_done, 5'h00,
						s.acc_op, s.acc_data, s.acc_addr};
				end
				loader_pkg::OFS_EXA0, loader_pkg::OFS_EXA1,
				loader_pkg::OFS_EXA2, loader_pkg::OFS_EXA3: begin
					next_s.rdata = s.exa[{reg_in.addr[3:2], 2'b00} +: 4];
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end

		// register writes; hardware events below override
		if (reg_in.wr) begin
			case (reg_in.addr)
				loader_pkg::OFS_CTL: begin
					next_s.ign = reg_in.wdata[loader_pkg::CTL_IGN];
				end
				loader_pkg::OFS_SWC: begin
					next_s.halt = reg_in.wdata[loader_pkg::SWC_HALT];
				end
				loader_pkg::OFS_STS: begin
					next_s.sts = s.sts & ~(reg_in.wdata[loader_pkg::ST_W-1:0]
						& loader_pkg::ST_W1C);
				end
				loader_pkg::OFS_ACC: begin
					if (!s.acc_busy) begin
						next_s.acc_addr = reg_in.wdata[15:0];
						next_s.acc_op = reg_in.wdata[loader_pkg::ACC_OP];
						next_s.acc_data =
							reg_in.wdata[loader_pkg::ACC_DATA +: 8];
						next_s.acc_busy = 1'b1;
						next_s.acc_done = 1'b0;
						next_s.acc_go = 1'b1;
					end
				end
				loader_pkg::OFS_EXA0, loader_pkg::OFS_EXA1,
				loader_pkg::OFS_EXA2, loader_pkg::OFS_EXA3: begin
					next_s.exa[{reg_in.addr[3:2], 2'b00} +: 4] =
						reg_in.wdata;
				end
				default: begin
					next_s.rdata = next_s.rdata;
				end
			endcase
		end

		// start of loading after strap settles
		if (s.lst == loader_pkg::LD_WAIT) begin
			if (s.wait_cnt == loader_pkg::STRAP_WAIT) begin
				if (s.en_s2) begin
					next_s.lst = loader_pkg::LD_RUN;
				end else begin
					next_s.lst = loader_pkg::LD_END;
					next_s.sts[loader_pkg::ST_DONE] = 1'b1;
				end
			end else begin
				next_s.wait_cnt = s.wait_cnt + 3'h1;
			end
		end

		// single master bus arbiter
		case (s.bst)
			loader_pkg::BS_IDLE: begin
				if (s.acc_go) begin
					next_s.acc_go = 1'b0;
					next_s.own = loader_pkg::OW_ACC;
					next_s.bst = loader_pkg::BS_BUSY;
					next_s.start = 1'b1;
					next_s.req.dev = {loader_pkg::PROM_HI, s.sel_s2};
					next_s.req.write = s.acc_op;
					next_s.req.wide = 1'b0;
					next_s.req.index = s.acc_addr;
					next_s.req.wdata = {8'h00, s.acc_data};
				end else if (s.lst == loader_pkg::LD_RUN) begin
					next_s.own = loader_pkg::OW_LOAD;
					next_s.bst = loader_pkg::BS_BUSY;
					next_s.start = 1'b1;
					next_s.req.dev = {loader_pkg::PROM_HI, s.sel_s2};
					next_s.req.write = 1'b0;
					next_s.req.wide = 1'b0;
					next_s.req.index = s.img_addr;
					next_s.req.wdata = 16'h0000;
				end else if (s.lst == loader_pkg::LD_END) begin
					if (s.exa[s.exi][6:0] != 7'h00) begin
						next_s.own = loader_pkg::OW_EXP;
						next_s.bst = loader_pkg::BS_BUSY;
						next_s.start = 1'b1;
						next_s.req.dev = s.exa[s.exi][6:0];
						next_s.req.write = !exp_rd;
						next_s.req.wide = 1'b1;
						next_s.req.index = exp_rd ? loader_pkg::EXP_IN_REG
							: loader_pkg::EXP_OUT_REG;
						next_s.req.wdata = exp_wd[s.exi];
					end else begin
						next_s.exi = exi_nx;
					end
				end
			end
			loader_pkg::BS_BUSY: begin
				if (bus_ans_in.done) begin
					next_s.bst = loader_pkg::BS_IDLE;
					case (s.own)
						loader_pkg::OW_LOAD: begin
							if (bus_ans_in.nack) begin
								fin = loader_pkg::PD_NACK;
							end else if (bus_ans_in.frame_err) begin
								fin = loader_pkg::PD_FRAME;
							end else begin
								next_s.sum = s.sum + b;
								if (s.ff_cnt != loader_pkg::BLANK_N) begin
									if (b == loader_pkg::BLANK_BYTE) begin
										next_s.ff_cnt = s.ff_cnt + 9'h001;
									end else begin
										next_s.seen_other = 1'b1;
									end
								end
								if (s.pend == loader_pkg::PD_NONE) begin
									if (s.rem == 18'h00000) begin
										next_s.btype = b[1:0];
										next_s.hdr = 1'b0;
										case (b[1:0])
											loader_pkg::BT_SINGLE: begin
												next_s.rem = loader_pkg::SINGLE_LEN;
											end
											loader_pkg::BT_SEQ: begin
												next_s.rem = loader_pkg::SEQ_HDR;
												next_s.hdr = 1'b1;
											end
											loader_pkg::BT_END: begin
												next_s.rem = loader_pkg::END_LEN;
											end
											default: begin
												next_s.pend = loader_pkg::PD_TYPE;
											end
										endcase
									end else begin
										next_s.rem = s.rem - 18'h00001;
										if (s.hdr && s.rem == 18'h00002) begin
											next_s.nlo = b;
										end
										if (s.hdr && s.rem == 18'h00001) begin
											next_s.rem = {b, s.nlo, 2'b00};
											next_s.hdr = 1'b0;
										end
										if (s.btype == loader_pkg::BT_END &&
											s.rem == 18'h00001) begin
											next_s.pend =
												(next_s.sum == loader_pkg::SUM_OK ||
												s.ign) ? loader_pkg::PD_OK
												: loader_pkg::PD_SUM;
										end
									end
								end
								if (!next_s.seen_other &&
									next_s.ff_cnt == loader_pkg::BLANK_N) begin
									fin = loader_pkg::PD_BLANK;
								end else if (next_s.pend != loader_pkg::PD_NONE
									&& next_s.seen_other) begin
									fin = next_s.pend;
								end else if (s.img_addr == loader_pkg::IMG_LAST)
								begin
									fin = loader_pkg::PD_ROLL;
								end else begin
									next_s.img_addr = s.img_addr + 16'h0001;
								end
							end
						end
						loader_pkg::OW_ACC: begin
							next_s.acc_busy = 1'b0;
							next_s.acc_done = 1'b1;
							if (!s.acc_op) begin
								next_s.acc_data = b;
							end
							if (bus_ans_in.nack) begin
								next_s.sts[loader_pkg::ST_NACK] = 1'b1;
							end
							if (bus_ans_in.frame_err) begin
								next_s.sts[loader_pkg::ST_FRAME] = 1'b1;
							end
						end
						default: begin
							next_s.exi = exi_nx;
							if (bus_ans_in.nack) begin
								next_s.sts[loader_pkg::ST_NACK] = 1'b1;
							end
							if (bus_ans_in.frame_err) begin
								next_s.sts[loader_pkg::ST_FRAME] = 1'b1;
							end else if (!bus_ans_in.nack) begin
								if (s.exi == loader_pkg::EXP_MRL) begin
									next_s.retention_latch_input = bus_ans_in.rdata;
								end
								if (s.exi == loader_pkg::EXP_PRST) begin
									next_s.prst = bus_ans_in.rdata;
								end
							end
						end
					endcase
				end
			end
			default: begin
				next_s.bst = loader_pkg::BS_IDLE;
			end
		endcase

		// end of loading and its outcome
		if (fin != loader_pkg::PD_NONE) begin
			next_s.lst = loader_pkg::LD_END;
			next_s.sts[loader_pkg::ST_DONE] = 1'b1;
			case (fin)
				loader_pkg::PD_SUM, loader_pkg::PD_TYPE: begin
					next_s.sts[loader_pkg::ST_SUM] = 1'b1;
					next_s.halt = 1'b1;
				end
				loader_pkg::PD_NACK: begin
					next_s.sts[loader_pkg::ST_NACK] = 1'b1;
					next_s.halt = 1'b1;
				end
				loader_pkg::PD_FRAME: begin
					next_s.sts[loader_pkg::ST_FRAME] = 1'b1;
					next_s.halt = 1'b1;
				end
				loader_pkg::PD_ROLL: begin
					next_s.sts[loader_pkg::ST_ROLL] = 1'b1;
					next_s.halt = 1'b1;
				end
				loader_pkg::PD_BLANK: begin
					next_s.sts[loader_pkg::ST_BLANK] = 1'b1;
				end
				default: begin
					next_s.halt = next_s.halt;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= loader_pkg::STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_out = s.rdata;
	assign bus_req_out = s.req;
	assign bus_start_out = s.start;
	assign retention_latch_input_out = s.retention_latch_input;
	assign prst_out = s.prst;
	assign halt_out = s.halt;
	assign load_done_out = s.sts[loader_pkg::ST_DONE];
endmodule : prom_loader

/* design/loader_pkg.sv */
// Overview of operation
// - image valid only when 8-bit sum of all bytes, done block included, is 0xFF
// - ignore-sum control bit skips the sum comparison and its error
// - any load error except blank stops loading and sets the hold bit
// - finished flag set on normal end, abort or error
// - sum mismatch sets sum error, hold bit, aborts, sets finished
// - block type 0x2 sets sum error, hold bit, aborts, sets finished
// - unexpected bus nack sets nack error, hold bit, aborts, sets finished
// - misplaced start or stop sets framing error, hold, aborts, finished
// - image address wrap sets rollover, hold bit, aborts, sets finished
// - blank part sets blank bit, aborts, sets finished, never hold
// - write of access data while idle starts a byte read
// - read completion sets done, clears busy, returns byte in data field
// - write of access data while idle starts a byte write; done, not busy
// - bus errors of access transfers show in the status register
// - up to 14 expanders of 16 pins, each input or output
// - expanders 0..7 carry two ports' hot-plug, lower and upper byte
// - expander 8 latch inputs, 9 and 10 interlocks of ports 0-7, 8-15
// - expander 11 partition resets, 12 link status, 13 link activity
// - link LED pins driven active low; hot-plug bits not inverted
// - no expander transaction before loading has finished
// - block types 0x0 single, 0x1 sequential, 0x3 done with sum
// - first 256 bytes all 0xFF means blank; checksum ignored
package loader_pkg;
	localparam int         EXP_N      = 14;
	localparam int         PORT_N     = 16;
	localparam logic [3:0] EXP_LAST   = 4'hD;
	localparam logic [3:0] EXP_MRL    = 4'h8;
	localparam logic [3:0] EXP_PRST   = 4'hB;
	localparam logic [7:0] OFS_CTL    = 8'h00;
	localparam logic [7:0] OFS_SWC    = 8'h04;
	localparam logic [7:0] OFS_STS    = 8'h08;
	localparam logic [7:0] OFS_ACC    = 8'h0C;
	localparam logic [7:0] OFS_EXA0   = 8'h10;
	localparam logic [7:0] OFS_EXA1   = 8'h14;
	localparam logic [7:0] OFS_EXA2   = 8'h18;
	localparam logic [7:0] OFS_EXA3   = 8'h1C;
	localparam int         CTL_IGN    = 0;
	localparam int         SWC_HALT   = 0;
	localparam int         ST_DONE    = 0;
	localparam int         ST_SUM     = 1;
	localparam int         ST_NACK    = 2;
	localparam int         ST_FRAME   = 3;
	localparam int         ST_ROLL    = 4;
	localparam int         ST_BLANK   = 5;
	localparam int         ST_W       = 6;
	localparam logic [5:0] ST_W1C     = 6'h0C;
	localparam int         ACC_DATA   = 16;
	localparam int         ACC_OP     = 24;
	localparam int         ACC_DONE   = 30;
	localparam int         ACC_BUSY   = 31;
	localparam logic [1:0] BT_SINGLE  = 2'h0;
	localparam logic [1:0] BT_SEQ     = 2'h1;
	localparam logic [1:0] BT_END     = 2'h3;
	localparam logic [17:0] SINGLE_LEN = 18'h00006;
	localparam logic [17:0] SEQ_HDR   = 18'h00004;
	localparam logic [17:0] END_LEN   = 18'h00001;
	localparam logic [7:0] SUM_OK     = 8'hFF;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [8:0] BLANK_N    = 9'h100;
	localparam logic [15:0] IMG_LAST  = 16'hFFFF;
	localparam logic [2:0] PROM_HI    = 3'h5;
	localparam logic [15:0] EXP_OUT_REG = 16'h0002;
	localparam logic [15:0] EXP_IN_REG  = 16'h0000;
	localparam logic [2:0] STRAP_WAIT = 3'h3;

	typedef enum logic [1:0] {LD_WAIT, LD_RUN, LD_END} load_st_t;
	typedef enum logic {BS_IDLE, BS_BUSY} bus_st_t;
	typedef enum logic [1:0] {OW_LOAD, OW_ACC, OW_EXP} owner_t;
	typedef enum logic [2:0] {PD_NONE, PD_OK, PD_SUM, PD_TYPE, PD_NACK,
		PD_FRAME, PD_ROLL, PD_BLANK} pend_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [6:0]  dev;
		logic        write;
		logic        wide;
		logic [15:0] index;
		logic [15:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic        done;
		logic        nack;
		logic        frame_err;
		logic [15:0] rdata;
	} bus_ans_t;

	typedef struct packed {
		load_st_t         lst;
		bus_st_t          bst;
		owner_t           own;
		pend_t            pend;
		logic             en_s1;
		logic             en_s2;
		logic [3:0]       sel_s1;
		logic [3:0]       sel_s2;
		logic [2:0]       wait_cnt;
		logic             ign;
		logic             halt;
		logic [ST_W-1:0]  sts;
		logic [7:0]       sum;
		logic [15:0]      img_addr;
		logic [8:0]       ff_cnt;
		logic             seen_other;
		logic [1:0]       btype;
		logic             hdr;
		logic [17:0]      rem;
		logic [7:0]       nlo;
		logic [15:0]      acc_addr;
		logic             acc_op;
		logic [7:0]       acc_data;
		logic             acc_busy;
		logic             acc_done;
		logic             acc_go;
		logic [15:0][7:0] exa;
		logic [3:0]       exi;
		logic [15:0]      retention_latch_input;
		logic [15:0]      prst;
		bus_req_t         req;
		logic             start;
		logic [31:0]      rdata;
	} state_t;

	localparam state_t STATE_RST = '0;
endpackage : loader_pkg

/* sim/prom_loader_chk_asserts.sv */
`timescale 1ns/10ps
// ==========================================================
// port checker for the loader
module prom_loader_chk #(
	parameter int N_EXP = 14
) (
	input wire logic             core_clk_in,   // clock
	input wire logic             rst_n_in,      // reset
	input wire logic             load_en_in,    // strap
	input wire logic [3:0]       prom_sel_in,   // prom pins
	input loader_pkg::reg_req_t  reg_in,        // reg request
	input wire logic [31:0]      reg_rdata_out, // reg data
	input loader_pkg::bus_req_t  bus_req_out,   // bus fields
	input wire logic             bus_start_out, // bus start
	input loader_pkg::bus_ans_t  bus_ans_in,    // bus answer
	input wire logic [15:0][7:0] hp_out_in,     // hot-plug
	input wire logic [15:0]      ilock_in,      // interlocks
	input wire logic [15:0]      link_up_in,    // link up
	input wire logic [15:0]      link_act_in,   // activity
	input wire logic [15:0]      retention_latch_input_out, // latches
	input wire logic [15:0]      prst_out,      // resets
	input wire logic             halt_out,      // hold
	input wire logic             load_done_out  // done
);
	logic inflight;
	logic exp_rd;

	// one transfer outstanding between start and done
	always_ff @(posedge core_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			inflight <= 1'b0;
		else if (bus_start_out)
			inflight <= 1'b1;
		else if (bus_ans_in.done)
			inflight <= 1'b0;

	assign exp_rd = bus_ans_in.done && bus_req_out.wide && !bus_req_out.write;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence ld_start;
		bus_start_out && !bus_req_out.wide;
	endsequence
	sequence exp_start;
		bus_start_out && bus_req_out.wide;
	endsequence

	no_early_exp_a: assert property (exp_start |-> load_done_out)
		else $error("expander transfer before load end");
	one_xfer_a: assert property (bus_start_out |-> !inflight)
		else $error("second transfer while one open");
	start_pulse_a: assert property (bus_start_out |=> !bus_start_out)
		else $error("start longer than one cycle");
	req_hold_a: assert property (!bus_start_out |-> $stable(bus_req_out))
		else $error("bus fields moved without start");
	prom_dev_a: assert property (ld_start |->
		bus_req_out.dev == {loader_pkg::PROM_HI, prom_sel_in})
		else $error("prom transfer to wrong device");
	done_hold_a: assert property (load_done_out |=> load_done_out)
		else $error("load finished flag dropped");
	rd_idle_a: assert property (!$past(reg_in.rd) |-> reg_rdata_out == 32'h0)
		else $error("read data outside read slot");
	latch_src_a: assert property ($changed(retention_latch_input_out)
		|-> $past(exp_rd))
		else $error("latch inputs moved without expander read");
	prst_src_a: assert property ($changed(prst_out) |-> $past(exp_rd))
		else $error("partition resets moved without expander read");
endmodule : prom_loader_chk

bind prom_loader prom_loader_chk #(.N_EXP(N_EXP)) chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .load_en_in(load_en_in),
	.prom_sel_in(prom_sel_in), .reg_in(reg_in), .reg_rdata_out(reg_rdata_out),
	.bus_req_out(bus_req_out), .bus_start_out(bus_start_out),
	.bus_ans_in(bus_ans_in), .hp_out_in(hp_out_in), .ilock_in(ilock_in),
	.link_up_in(link_up_in), .link_act_in(link_act_in),
	.retention_latch_input_out(retention_latch_input_out),
	.prst_out(prst_out), .halt_out(halt_out), .load_done_out(load_done_out));

/* sim/prom_far_model.sv */
`timescale 1ns/10ps
// ==========================================================
// serial prom and expanders on the master bus
module prom_far_model (
	input  wire logic            clk_in,    // core clock
	input  wire logic            rst_n_in,  // reset
	input  loader_pkg::bus_req_t req_in,    // transfer fields
	input  wire logic            start_in,  // start pulse
	output loader_pkg::bus_ans_t ans_out,   // answer
	input  wire logic [3:0]      lat_in,    // answer delay
	input  wire logic [1:0]      err_in,    // 1 nack, 2 framing
	input  wire logic [15:0]     err_at_in  // faulty byte address
);
	logic [7:0]           mem [0:65535];
	logic [15:0]          last_w [0:127];
	int                   xcnt;
	logic                 busy;
	logic [3:0]           cnt;
	loader_pkg::bus_req_t cur;
	logic                 hit;

	initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
	assign hit = !cur.wide && cur.index == err_at_in;

	always @(posedge clk_in or negedge rst_n_in) begin
		ans_out.done <= 1'b0;
		ans_out.nack <= 1'b0;
		ans_out.frame_err <= 1'b0;
		// released data never repeats the last value
		ans_out.rdata <= ~ans_out.rdata;
		if (!rst_n_in) begin
			busy <= 1'b0;
			xcnt <= 0;
			ans_out.rdata <= 16'h5A5A;
		end else if (start_in) begin
			busy <= 1'b1;
			cur <= req_in;
			cnt <= lat_in;
		end else if (busy && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (busy) begin
			busy <= 1'b0;
			ans_out.done <= 1'b1;
			ans_out.nack <= err_in == 2'h1 && hit;
			ans_out.frame_err <= err_in == 2'h2 && hit;
			if (cur.wide) begin
				xcnt <= xcnt + 1;
				ans_out.rdata <= {cur.dev, 1'b0, ~cur.dev, 1'b1};
			end else
				ans_out.rdata <= {8'h00, mem[cur.index]};
			if (cur.wide && cur.write)
				last_w[cur.dev] <= cur.wdata;
			if (!cur.wide && cur.write)
				mem[cur.index] <= cur.wdata[7:0];
		end
	end
endmodule : prom_far_model

/* sim/prom_loader_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module prom_loader_tb;
	logic                 core_clk_in;
	logic                 rst_n_in = 1'b0;
	loader_pkg::reg_req_t reg_in = '0;
	logic [31:0]          reg_rdata_out;
	loader_pkg::bus_req_t bus_req_out;
	logic                 bus_start_out;
	loader_pkg::bus_ans_t bus_ans_in;
	logic [15:0][7:0]     hp;
	logic [15:0]          ilk = 16'hA5C3;
	logic [15:0]          lup = 16'h0F35;
	logic [15:0]          lact = 16'h9A61;
	logic [15:0]          latch_q, prst_q;
	logic                 halt, ldone;
	logic [3:0]           lat = 4'h0;
	logic [1:0]           err = 2'h0;
	logic [15:0]          err_at = 16'h0003;
	int                   n_mismatch, num_checks, cyc, lo;
	logic [31:0]          w;
	logic [7:0]           s;
	// single block, sequential block of one dword, done block
	logic [7:0]           img [0:16] = '{8'h00, 8'h3F, 8'h3F, 8'h11,
		8'h22, 8'h33, 8'h44, 8'h01, 8'h40, 8'h00, 8'h01, 8'h00,
		8'h55, 8'h66, 8'h77, 8'h88, 8'h03};
	logic                 ld_en = 1'b1;
	logic [31:0]          exa [0:3] = '{32'h23222120, 32'h27262524,
		32'h2B2A2928, 32'h00002D2C};
	// cases: bad sum, ignored bad sum, type 2, nack, framing, blank, good,
	// strap low over a blank part
	logic [1:0]           kinds [0:7] = '{1, 1, 2, 0, 0, 3, 0, 3};
	logic [3:0]           lats [0:7] = '{5, 0, 1, 0, 3, 0, 2, 0};
	logic [1:0]           errs [0:7] = '{0, 0, 0, 1, 2, 0, 0, 0};
	logic [5:0]           sts [0:7] = '{6'h03, 6'h01, 6'h03, 6'h05, 6'h09,
		6'h21, 6'h01, 6'h01};
	logic                 halts [0:7] = '{1, 0, 1, 1, 1, 0, 0, 0};

	prom_loader #(.N_EXP(14)) dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .load_en_in(ld_en),
		.prom_sel_in(4'h6), .reg_in(reg_in), .reg_rdata_out(reg_rdata_out),
		.bus_req_out(bus_req_out), .bus_start_out(bus_start_out),
		.bus_ans_in(bus_ans_in), .hp_out_in(hp), .ilock_in(ilk),
		.link_up_in(lup), .link_act_in(lact),
		.retention_latch_input_out(latch_q), .prst_out(prst_q),
		.halt_out(halt), .load_done_out(ldone));
	prom_far_model pm (
		.clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_in(bus_req_out),
		.start_in(bus_start_out), .ans_out(bus_ans_in), .lat_in(lat),
		.err_in(err), .err_at_in(err_at));

	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk_in);
		reg_in <= '0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		reg_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk_in);
		reg_in <= '0;
		#1 d = reg_rdata_out;
	endtask : rd

	// one byte access, waits for busy to fall
	task acc(input logic op, input logic [15:0] a, input logic [7:0] d,
		output logic [31:0] q);
		rd(loader_pkg::OFS_ACC, q);
		`CHK(q[loader_pkg::ACC_BUSY], 1'b0)
		wr(loader_pkg::OFS_ACC, {7'h00, op, d, a});
		q = 32'h8000_0000;
		for (int i = 0; i < 300 && q[loader_pkg::ACC_BUSY] !== 1'b0; i++)
			rd(loader_pkg::OFS_ACC, q);
		`CHK(q[31:30], 2'b01)
	endtask : acc

	initial begin
		for (int p = 0; p < 16; p++) hp[p] = {4'hC, 4'(p)};
		// let the model fill its memory before the image goes in
		@(posedge core_clk_in);
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 512; i++) pm.mem[i] = 8'hFF;
			s = 8'h00;
			for (int i = 0; i < 17 && kinds[k] != 2'h3; i++) begin
				pm.mem[i] = img[i];
				s += img[i];
			end
			if (kinds[k] != 2'h3)
				pm.mem[17] = (8'hFF - s) ^ {7'h00, kinds[k] == 2'h1};
			if (kinds[k] == 2'h2)
				pm.mem[0] = 8'h02;
			@(posedge core_clk_in);
			rst_n_in <= 1'b0;
			err <= errs[k];
			lat <= lats[k];
			ld_en <= (k != 7);
			repeat (2) @(posedge core_clk_in);
			rst_n_in <= 1'b1;
			if (k == 1)
				wr(loader_pkg::OFS_CTL, 32'h1);
			for (int i = 0; i < 4; i++)
				wr(loader_pkg::OFS_EXA0 + 8'(4 * i), exa[i]);
			for (int i = 0; i < 3000 && ldone !== 1'b1; i++)
				@(posedge core_clk_in);
			`CHK(ldone, 1'b1)
			rd(loader_pkg::OFS_STS, w);
			`CHK(w[5:0], sts[k])
			`CHK(halt, halts[k])
			$display("load case %0d finished", k);
		end
		for (int i = 0; i < 4000 && pm.xcnt < 28; i++) @(posedge core_clk_in);
		for (int e = 0; e < 8; e++) begin
			lo = 4 * (e / 2) + e % 2;
			`CHK(pm.last_w[8'h20 + e], {hp[lo + 2], hp[lo]})
		end
		`CHK(pm.last_w[8'h29], {8'h00, ilk[7:0]})
		`CHK(pm.last_w[8'h2A], {8'h00, ilk[15:8]})
		`CHK(pm.last_w[8'h2C], ~lup)
		`CHK(pm.last_w[8'h2D], ~lact)
		`CHK(latch_q, {7'h28, 1'b0, ~7'h28, 1'b1})
		`CHK(prst_q, {7'h2B, 1'b0, ~7'h2B, 1'b1})
		$display("expander test finished");
		acc(1'b1, 16'h0100, 8'h5A, w);
		`CHK(pm.mem[16'h0100], 8'h5A)
		pm.mem[16'h0101] = 8'hC3;
		acc(1'b0, 16'h0101, 8'h00, w);
		`CHK(w[23:16], 8'hC3)
		err <= 2'h1;
		err_at <= 16'h0102;
		acc(1'b0, 16'h0102, 8'h00, w);
		rd(loader_pkg::OFS_STS, w);
		`CHK(w[5:0], 6'h05)
		`CHK(halt, 1'b0)
		wr(loader_pkg::OFS_STS, 32'h4);
		rd(loader_pkg::OFS_STS, w);
		`CHK(w[5:0], 6'h01)
		$display("access test finished");
		stop_test();
	end
endmodule : prom_loader_tb
